// ---- nhisp_defs.svh ----
// constants for the host two-wire slave port
//
// Contract
// [RULE_01] answer only address 010100 plus strap bit
// [RULE_02] work at 100 kHz, 400 kHz, 3.4 MHz
// [RULE_03] standby wake only on own address
// [RULE_04] device may stretch clock; master waits
// [RULE_05] no general call, 10-bit, or Fm+
// [RULE_06] interrupt line with configurable active polarity
// [RULE_07] own shift register, timing, hardware address match
// [RULE_08] pins serve bus only when nvm selects it
// [RULE_09] wake source in standby moves to active
// [RULE_10] interrupt while data pending, cleared after read
`ifndef NHISP_DEFS_SVH
`define NHISP_DEFS_SVH

// =====================================================================
// addressing
`define NHISP_ADDR_HDR 6'h14
`define NHISP_BITS_PER_BYTE 4'h8

// =====================================================================
// timing
`define NHISP_SYS_CLK_HZ 40000000
`define NHISP_SM_SCL_HZ 100000
`define NHISP_FM_SCL_HZ 400000
`define NHISP_HS_SCL_HZ 3400000
// system clocks per fastest serial clock period, rounded down
`define NHISP_HS_SCL_CYC (`NHISP_SYS_CLK_HZ / `NHISP_HS_SCL_HZ)

`endif

// ---- nhisp_host_model.sv ----
// bus master model standing in for the host processor
`timescale 1ns/1ps
module nhisp_host_model (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    initial {scl_low_o, sda_low_o} = 2'b00;
    // ==========
    // bit level, 200 ns clock period
    task automatic bit_xfer(input logic b, output logic r);
        int n;
        sda_low_o = !b;
        #50 scl_low_o = 1'b0;
        for (n = 0; n < 2000 && !scl_i; n++) #5;  // waits out a held clock
        #100 r = sda_i;
        scl_low_o = 1'b1;
        #50;
    endtask : bit_xfer
    task automatic edge_cond(input logic st);  // start when st, else stop
        sda_low_o = !st;
        #50 scl_low_o = 1'b0;
        #100 sda_low_o = st;
        #100 scl_low_o = st;
        #50;
    endtask : edge_cond
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);  // msb first
        bit_xfer(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(!more, r);  // nack ends the read
    endtask : rd_byte
endmodule : nhisp_host_model

// ---- nhisp_pkg.sv ----
// types for the host two-wire slave port
package nhisp_pkg;

    typedef enum logic [5:0] {
        NHISP_IDLE = 6'h01,
        NHISP_ADDR = 6'h02,
        NHISP_AACK = 6'h04,
        NHISP_RX   = 6'h08,
        NHISP_RACK = 6'h10,
        NHISP_TX   = 6'h20
    } nhisp_state_e;

endpackage : nhisp_pkg

// ---- nhisp_port.sv ----
// two-wire slave port with wake, stretch and host interrupt
`timescale 1ns/1ps
`include "nhisp_defs.svh"

module nhisp_port
    import nhisp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic bus_sel_i,
    input wire logic addr_select_strap_i,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_o,
    input wire logic irq_active_high_i,
    output logic irq_o,
    input wire logic notify_i,
    input wire logic standby_req_i,
    input wire logic wake_src_i,
    output logic active_o,
    output logic wake_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_taken_o
);

    // =================================================================
    // pin synchronisers
    logic [2:0] scl_q, scl_d;
    logic [2:0] sda_q, sda_d;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        scl_d = {scl_q[1:0], serial_clock_pin_i}; // [RULE_02]
        sda_d = {sda_q[1:0], serial_data_pin_i};
        // first stage feeds only the second; edges come from stages 2 and 3
        scl_rise = scl_q[1] & ~scl_q[2];
        scl_fall = ~scl_q[1] & scl_q[2];
        start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
        stop_det = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // =================================================================
    // address match
    function automatic logic own_addr(input logic [7:0] b, input logic strap);
        // general call and 10-bit headers never equal this pattern
        own_addr = (b[7:2] == `NHISP_ADDR_HDR) && (b[1] == strap); // [RULE_01] [RULE_05]
    endfunction : own_addr

    logic strap_q, strap_d;

    // =================================================================
    // protocol engine
    nhisp_state_e state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] cnt_q, cnt_d;
    logic rw_q, rw_d;
    logic nack_q, nack_d;
    logic stretch_q, stretch_d;
    logic sda_oe_q, sda_oe_d;
    logic rx_valid_q, rx_valid_d;
    logic [7:0] rx_data_q, rx_data_d;
    logic tx_taken_q, tx_taken_d;
    logic read_seen_q, read_seen_d;
    logic match_ev;
    logic load_now;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        rw_d = rw_q;
        nack_d = nack_q;
        stretch_d = stretch_q;
        sda_oe_d = sda_oe_q;
        rx_valid_d = 1'b0;
        rx_data_d = rx_data_q;
        tx_taken_d = 1'b0;
        read_seen_d = read_seen_q;
        match_ev = 1'b0;
        load_now = 1'b0;
        strap_d = strap_q;

        if (!bus_sel_i) begin
            // pins belong to another function: release everything
            state_d = NHISP_IDLE; // [RULE_08]
            sda_oe_d = 1'b0;
            stretch_d = 1'b0;
            read_seen_d = 1'b0;
        end else if (start_det) begin
            state_d = NHISP_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
            stretch_d = 1'b0;
            strap_d = addr_select_strap_i;
        end else if (stop_det) begin
            state_d = NHISP_IDLE;
            sda_oe_d = 1'b0;
            stretch_d = 1'b0;
            read_seen_d = 1'b0;
        end else if (stretch_q) begin
            // clock held low until a byte is offered, then one cycle more so data settles before the clock goes
            if (tx_taken_q) begin
                stretch_d = 1'b0;
            end else if (tx_valid_i) begin
                load_now = 1'b1; // [RULE_04]
            end
        end else begin
            case (state_q)
                NHISP_ADDR, NHISP_RX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_q[2]}; // [RULE_07]
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `NHISP_BITS_PER_BYTE) begin
                        cnt_d = 4'h0;
                        if (state_q == NHISP_RX) begin
                            rx_data_d = shift_q;
                            rx_valid_d = 1'b1;
                            sda_oe_d = 1'b1;
                            state_d = NHISP_RACK;
                        end else if (own_addr(shift_q, strap_q)) begin
                            match_ev = 1'b1;
                            rw_d = shift_q[0];
                            sda_oe_d = 1'b1;
                            state_d = NHISP_AACK;
                        end else begin
                            state_d = NHISP_IDLE;
                        end
                    end
                end
                NHISP_RACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        state_d = NHISP_RX;
                    end
                end
                NHISP_AACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        if (!rw_q) begin
                            state_d = NHISP_RX;
                        end else if (tx_valid_i) begin
                            load_now = 1'b1;
                        end else begin
                            stretch_d = 1'b1; // [RULE_04]
                        end
                    end
                end
                NHISP_TX: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == `NHISP_BITS_PER_BYTE) begin
                            nack_d = sda_q[2];
                        end
                    end else if (scl_fall) begin
                        if (cnt_q == `NHISP_BITS_PER_BYTE) begin
                            sda_oe_d = 1'b0;
                        end else if (cnt_q > `NHISP_BITS_PER_BYTE) begin
                            if (nack_q) begin
                                state_d = NHISP_IDLE;
                            end else if (tx_valid_i) begin
                                load_now = 1'b1;
                            end else begin
                                stretch_d = 1'b1; // [RULE_04]
                            end
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            sda_oe_d = ~shift_q[6];
                        end
                    end
                end
                default: begin
                    state_d = NHISP_IDLE;
                end
            endcase
        end

        if (load_now) begin
            shift_d = tx_data_i; // [RULE_07]
            sda_oe_d = ~tx_data_i[7];
            cnt_d = 4'h0;
            nack_d = 1'b0;
            tx_taken_d = 1'b1;
            read_seen_d = 1'b1;
            state_d = NHISP_TX;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= NHISP_IDLE;
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            stretch_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
            tx_taken_q <= 1'b0;
            read_seen_q <= 1'b0;
            strap_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            rw_q <= rw_d;
            nack_q <= nack_d;
            stretch_q <= stretch_d;
            sda_oe_q <= sda_oe_d;
            rx_valid_q <= rx_valid_d;
            rx_data_q <= rx_data_d;
            tx_taken_q <= tx_taken_d;
            read_seen_q <= read_seen_d;
            strap_q <= strap_d;
        end
    end

    // =================================================================
    // power state, wake and host interrupt
    logic active_q, active_d;
    logic wake_q, wake_d;
    logic pending_q, pending_d;
    logic irq_q, irq_d;

    always_comb begin
        active_d = active_q;
        wake_d = 1'b0;
        if (!active_q && (match_ev || wake_src_i)) begin
            // only own-address traffic reaches match_ev
            active_d = 1'b1; // [RULE_03] [RULE_09]
            wake_d = 1'b1;
        end else if (active_q && standby_req_i) begin
            active_d = 1'b0;
        end
        pending_d = pending_q;
        // clear after a read that moved data, new notice wins
        if (stop_det && read_seen_q) begin
            pending_d = 1'b0; // [RULE_10]
        end
        if (notify_i) begin
            pending_d = 1'b1; // [RULE_10]
        end
        irq_d = irq_active_high_i ? pending_q : ~pending_q; // [RULE_06]
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_q <= 1'b1;
            wake_q <= 1'b0;
            pending_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            active_q <= active_d;
            wake_q <= wake_d;
            pending_q <= pending_d;
            irq_q <= irq_d;
        end
    end

    // =================================================================
    // outputs
    logic pin_lo_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_lo_q <= 1'b0;
        end else begin
            pin_lo_q <= 1'b0;
        end
    end

    assign serial_clock_pin_o = pin_lo_q;
    assign serial_data_pin_o = pin_lo_q;
    assign serial_clock_pin_oe_o = stretch_q;
    assign serial_data_pin_oe_o = sda_oe_q;
    assign irq_o = irq_q;
    assign active_o = active_q;
    assign wake_o = wake_q;
    assign rx_data_o = rx_data_q;
    assign rx_valid_o = rx_valid_q;
    assign tx_taken_o = tx_taken_q;

endmodule : nhisp_port

// ---- nhisp_port_assertions.sv ----
// concurrent checks on the host two-wire slave port
`timescale 1ns/1ps
module nhisp_port_assertions (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic bus_sel_i,
    input wire logic serial_clock_pin_i,
    input wire logic serial_clock_pin_oe_o,
    input wire logic serial_data_pin_oe_o,
    input wire logic irq_active_high_i,
    input wire logic irq_o,
    input wire logic notify_i,
    input wire logic standby_req_i,
    input wire logic wake_src_i,
    input wire logic active_o,
    input wire logic wake_o,
    input wire logic tx_valid_i,
    input wire logic tx_taken_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ==========
    // sequences and checks
    sequence s_notify;  // polarity left alone while the flag lands
        notify_i ##1 $stable(irq_active_high_i) [*2];
    endsequence
    sequence s_wake_pulse;
        wake_o ##1 !wake_o;
    endsequence
    unsel_idle_a: assert property (!bus_sel_i [*2] |-> !serial_data_pin_oe_o && !serial_clock_pin_oe_o)
        else $error("pin driven while deselected");
    sda_scl_low_a: assert property ($changed(serial_data_pin_oe_o) |-> !serial_clock_pin_i)
        else $error("data moved while clock high");
    stretch_hold_a: assert property (serial_clock_pin_oe_o && !tx_valid_i && !tx_taken_o |=> serial_clock_pin_oe_o)
        else $error("clock let go with no data");
    taken_cause_a: assert property (tx_taken_o |-> $past(tx_valid_i) ##1 !tx_taken_o)
        else $error("bad take pulse");
    irq_set_a: assert property (s_notify |-> irq_o == irq_active_high_i)
        else $error("irq not at asserted level");
    wake_pulse_a: assert property ($rose(active_o) |-> s_wake_pulse)
        else $error("no single wake pulse");
    wake_cause_a: assert property (wake_o |-> $rose(active_o))
        else $error("wake without standby exit");
    wake_src_a: assert property (!active_o && wake_src_i && !standby_req_i |=> active_o)
        else $error("wake source ignored");
endmodule : nhisp_port_assertions
bind nhisp_port nhisp_port_assertions u_chk (.*);

// ---- nhisp_port_tb_top.sv ----
// self-checking bench for the host two-wire slave port
`timescale 1ns/1ps
module nhisp_port_tb_top;
    logic sys_clk_i = 1'b0, reset_n_i = 1'b0, bus_sel_i = 1'b1, addr_select_strap_i = 1'b0, irq_active_high_i = 1'b1;
    logic notify_i = 1'b0, standby_req_i = 1'b0, wake_src_i = 1'b0, tx_valid_i = 1'b0, stretch_seen = 1'b0;
    logic [7:0] tx_data_i = 8'h00, rx_data_o, rx_last;
    logic serial_clock_pin_o, serial_clock_pin_oe_o, serial_data_pin_o, serial_data_pin_oe_o, irq_o, active_o, wake_o;
    logic rx_valid_o, tx_taken_o, scl_low, sda_low;
    int miscompares = 0, cmp_count = 0, cyc = 0, wake_cnt = 0, take_cnt = 0;
    // released lines float high through the pull-ups
    wire serial_clock_pin_i = !(scl_low || (serial_clock_pin_oe_o && !serial_clock_pin_o));
    wire serial_data_pin_i = !(sda_low || (serial_data_pin_oe_o && !serial_data_pin_o));
    nhisp_port dut (.*);
    nhisp_host_model host (.scl_i(serial_clock_pin_i), .sda_i(serial_data_pin_i),
        .scl_low_o(scl_low), .sda_low_o(sda_low));
    always #12.5 sys_clk_i = !sys_clk_i;
    // ==========
    // helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic pulse(input int sel);  // 0 notify, 1 standby, 2 wake source
        @(posedge sys_clk_i);
        notify_i <= (sel == 0);
        standby_req_i <= (sel == 1);
        wake_src_i <= (sel == 2);
        @(posedge sys_clk_i);
        {notify_i, standby_req_i, wake_src_i} <= 3'h0;
        repeat (3) @(posedge sys_clk_i);
    endtask : pulse
    task automatic probe(input logic [7:0] a, output logic ack);
        host.edge_cond(1'b1);
        host.wr_byte(a, ack);
        host.edge_cond(1'b0);
    endtask : probe
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    always @(posedge sys_clk_i) begin
        if (rx_valid_o) rx_last = rx_data_o;
        if (wake_o) wake_cnt++;
        if (tx_taken_o) take_cnt++;
        if (serial_clock_pin_oe_o) stretch_seen = 1'b1;
        if (++cyc == 20000) begin  // whole run needs under two thousand cycles
            miscompares++;
            report_and_stop();
        end
    end
    // ==========
    // scenarios
    task automatic addr_scen();
        logic ack;
        logic [7:0] bad [4] = '{8'h52, 8'h00, 8'hf0, 8'h54};
        host.edge_cond(1'b1);
        host.wr_byte(8'h50, ack);
        check(8'(ack), 8'h01);
        host.wr_byte(8'hc3, ack);
        host.edge_cond(1'b0);
        check(8'(ack), 8'h01);
        check(rx_last, 8'hc3);
        foreach (bad[i]) begin
            probe(bad[i], ack);
            check(8'(ack), 8'h00);
        end
    endtask : addr_scen
    task automatic read_scen(input logic pol);
        logic ack;
        logic [7:0] b, b2;
        @(posedge sys_clk_i) addr_select_strap_i <= 1'b1;
        irq_active_high_i <= pol;
        stretch_seen = 1'b0;
        pulse(0);
        check(8'(irq_o), 8'(pol));
        host.edge_cond(1'b1);
        host.wr_byte(8'h53, ack);
        check(8'(ack), 8'h01);
        fork
            begin
                host.rd_byte(1'b1, b);
                host.rd_byte(1'b0, b2);
            end
            begin
                repeat (60) @(posedge sys_clk_i);
                tx_data_i <= {pol, 7'h35};
                tx_valid_i <= 1'b1;
            end
        join
        host.edge_cond(1'b0);
        repeat (6) @(posedge sys_clk_i);
        tx_valid_i <= 1'b0;
        check(b, {pol, 7'h35});
        check(b2, {pol, 7'h35});
        check({stretch_seen, irq_o, 6'(take_cnt)}, {2'b10 | 2'(!pol), pol ? 6'h02 : 6'h04});
        pulse(0);
        probe(8'h52, ack);
        check({6'h00, ack, irq_o}, {7'h01, pol});
    endtask : read_scen
    task automatic power_scen();
        logic ack;
        @(posedge sys_clk_i) bus_sel_i <= 1'b0;
        probe(8'h52, ack);
        check(8'(ack), 8'h00);
        @(posedge sys_clk_i) bus_sel_i <= 1'b1;
        pulse(1);
        probe(8'h50, ack);
        check({ack, active_o, 6'(wake_cnt)}, 8'h00);
        probe(8'h52, ack);
        check({active_o, 7'(wake_cnt)}, 8'h81);
        pulse(1);
        pulse(2);
        check({active_o, 7'(wake_cnt)}, 8'h82);
    endtask : power_scen
    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        addr_scen();
        read_scen(1'b1);
        read_scen(1'b0);
        power_scen();
        report_and_stop();
    end
endmodule : nhisp_port_tb_top
